// ### hdl/swl_phy.sv
// Single-wire link slave physical layer: interface states, current drive, power modes
`timescale 1ns/1ps
module swl_phy
  import swl_pkg::*;
#(
  parameter int PS_CYC = PS_CYC_DEF
)(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        master_voltage_signal,
  output logic             slave_current_signal,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata
);
  localparam int PSW = $clog2(PS_CYC + 1);

  logic           line_lvl;
  logic           rise_p;
  logic           fall_p;
  swl_bit_t       rx_bit;
  swl_ctrl_t      ctrl_r;
  swl_state_t     st_r;
  swl_pm_t        pm_r;
  logic [10:0]    run_cnt_r;
  logic [3:0]     evt_cnt_r;
  logic [5:0]     resp_cnt_r;
  logic [PSW-1:0] ps_cnt_r;
  logic           ps_r;
  logic           cur_r;
  logic [7:0]     tx_sh_r;
  logic [3:0]     tx_left_r;
  logic [7:0]     tx_byte_r;
  logic           tx_pend_r;
  logic [7:0]     rx_sh_r;
  logic           rx_new_r;
  logic           rx_err_r;
  logic           resp_err_r;
  logic [31:0]    rdata_r;
  logic [31:0]    stat_w;
  logic [10:0]    bit_max;
  logic           wr_ctrl;
  logic           wr_tx;
  logic           rd_stat;
  logic           pm_low_p;
  logic           pm_full_p;
  logic           nonact_p;
  logic           oif_full_p;
  logic           oif_res_p;
  logic           deact_hit;
  logic           susp_hit;
  logic           resp_to;
  logic           tx_load;
  logic           tx_run;
  logic           ps_cond;

  // Pulse-width decoder on the synchronised master voltage
  swl_bit_dec u_dec (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .volt_pin (master_voltage_signal),
    .ext_en   (ctrl_r.ext),
    .line_lvl (line_lvl),
    .rise_p   (rise_p),
    .fall_p   (fall_p),
    .rx_bit   (rx_bit)
  );

  // Register strobes and control pulses
  assign wr_ctrl    = reg_wr && reg_addr == REG_CTRL;
  assign wr_tx      = reg_wr && reg_addr == REG_TXD;
  assign rd_stat    = reg_rd && reg_addr == REG_STAT;
  assign pm_low_p   = wr_ctrl && reg_wdata[CB_PMLOW];
  assign pm_full_p  = wr_ctrl && reg_wdata[CB_PMFULL];
  assign nonact_p   = wr_ctrl && reg_wdata[CB_NONACT];
  assign oif_full_p = wr_ctrl && reg_wdata[CB_OIFFUL];
  assign oif_res_p  = wr_ctrl && reg_wdata[CB_OIFRES];

  // Line events; the suspend limit follows the agreed bit duration range
  assign bit_max   = ctrl_r.ext ? {3'h0, PER_MAX_EXT} : {3'h0, PER_MAX_DEF};
  assign deact_hit = !line_lvl && run_cnt_r >= DEACT_CYC && st_r != ST_DEACT;
  assign susp_hit  = line_lvl && run_cnt_r > bit_max && (st_r == ST_ACT || st_r == ST_MRES);
  assign resp_to   = st_r == ST_SRES && !fall_p && resp_cnt_r == RESP_CYC - 6'h01;
  assign tx_run    = st_r == ST_ACT || st_r == ST_MRES || st_r == ST_SRES;
  assign tx_load   = tx_run && fall_p && tx_left_r == 4'h0 && tx_pend_r && !deact_hit;
  assign ps_cond   = ctrl_r.idle && (st_r == ST_DEACT || (st_r == ST_SUSP && ctrl_r.nma));

  // Run length of the present line level, saturating
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      run_cnt_r <= 11'h000;
    end else if (rise_p || fall_p) begin
      run_cnt_r <= 11'h001;
    end else if (run_cnt_r != 11'h7FF) begin
      run_cnt_r <= run_cnt_r + 11'h001;
    end
  end

  // Interface state machine; deactivation overrides every state
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r <= ST_DEACT;
    end else if (deact_hit) begin
      st_r <= ST_DEACT;
    end else begin
      unique case (st_r)
        ST_DEACT: begin
          if (line_lvl)
            st_r <= ST_SUSP;
        end
        ST_SUSP: begin
          if (fall_p)
            st_r <= ST_MRES;
          else if (tx_pend_r)
            st_r <= ST_SRES;
        end
        ST_MRES: begin
          if (susp_hit)
            st_r <= ST_SUSP;
          else if (rx_bit.valid && evt_cnt_r == RESUME_EVT - 4'h1)
            st_r <= ST_ACT;
        end
        ST_SRES: begin
          if (fall_p)
            st_r <= ST_ACT;
          else if (resp_to)
            st_r <= ST_SUSP;
        end
        ST_ACT: begin
          if (susp_hit)
            st_r <= ST_SUSP;
        end
      endcase
    end
  end

  // Bits seen since the master's resume edge, transition bit included
  always_ff @(posedge sys_clk) begin
    if (sys_rst || st_r != ST_MRES) begin
      evt_cnt_r <= 4'h0;
    end else if (rx_bit.valid) begin
      evt_cnt_r <= evt_cnt_r + 4'h1;
    end
  end

  // Wait for the master's answer to a slave resume
  always_ff @(posedge sys_clk) begin
    if (sys_rst || st_r != ST_SRES) begin
      resp_cnt_r <= 6'h00;
    end else begin
      resp_cnt_r <= resp_cnt_r + 6'h01;
    end
  end

  // Current drive: bits switched at falling edges, so the master sees a settled level; slave wake and clears act at once
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cur_r     <= 1'b0;
      tx_sh_r   <= 8'h00;
      tx_left_r <= 4'h0;
    end else if (deact_hit || susp_hit || resp_to || st_r == ST_DEACT) begin
      cur_r     <= 1'b0;
      tx_left_r <= 4'h0;
    end else if (st_r == ST_SUSP) begin
      cur_r <= tx_pend_r && !fall_p;
    end else if (fall_p) begin
      if (tx_left_r != 4'h0) begin
        cur_r     <= tx_sh_r[7];
        tx_sh_r   <= {tx_sh_r[6:0], 1'b0};
        tx_left_r <= tx_left_r - 4'h1;
      end else if (tx_load) begin
        cur_r     <= tx_byte_r[7];
        tx_sh_r   <= {tx_byte_r[6:0], 1'b0};
        tx_left_r <= TX_LAST;
      end else begin
        cur_r <= 1'b0;
      end
    end
  end

  assign slave_current_signal = cur_r;

  // One-byte transmit holding register; a new write wins over the load
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tx_pend_r <= 1'b0;
      tx_byte_r <= 8'h00;
    end else if (wr_tx) begin
      tx_pend_r <= 1'b1;
      tx_byte_r <= reg_wdata[7:0];
    end else if (tx_load) begin
      tx_pend_r <= 1'b0;
    end
  end

  // Received bits, newest in bit 0; flags clear on status read unless set again
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rx_sh_r  <= 8'h00;
      rx_new_r <= 1'b0;
      rx_err_r <= 1'b0;
    end else begin
      if (rd_stat) begin
        rx_new_r <= 1'b0;
        rx_err_r <= 1'b0;
      end
      if (rx_bit.valid && st_r == ST_ACT) begin
        rx_sh_r  <= {rx_sh_r[6:0], rx_bit.val};
        rx_new_r <= 1'b1;
        if (rx_bit.err)
          rx_err_r <= 1'b1;
      end
    end
  end

  // Master missed the resume answer window
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      resp_err_r <= 1'b0;
    end else if (resp_to) begin
      resp_err_r <= 1'b1;
    end else if (rd_stat) begin
      resp_err_r <= 1'b0;
    end
  end

  // Power mode is chosen once per supply cycle; full wins a tie
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pm_r <= PM_INIT;
    end else if (pm_r == PM_INIT) begin
      if (pm_full_p || oif_full_p)
        pm_r <= PM_FULL;
      else if (pm_low_p || nonact_p)
        pm_r <= PM_LOW;
    end
  end

  // Power saving timer; long enough that tests shorten it by parameter
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !ps_cond || oif_res_p) begin
      ps_cnt_r <= '0;
    end else if (ps_cnt_r != PSW'(PS_CYC)) begin
      ps_cnt_r <= ps_cnt_r + PSW'(1);
    end
  end

  // Power saving flag; leaving the idle condition ends it
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ps_r <= 1'b0;
    end else if (ps_cond && !oif_res_p && ps_cnt_r == PSW'(PS_CYC - 1)) begin
      ps_r <= 1'b1;
    end else if (!ps_cond || oif_res_p) begin
      ps_r <= 1'b0;
    end
  end

  // Control register: steering bits stored, pulse bits only act
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r.ext  <= reg_wdata[CB_EXT];
      ctrl_r.idle <= reg_wdata[CB_IDLE];
      ctrl_r.nma  <= reg_wdata[CB_NMA];
    end
  end

  // Status word
  always_comb begin
    stat_w               = 32'h0000_0000;
    stat_w[SB_ST +: 3]   = st_r;
    stat_w[SB_PM +: 2]   = pm_r;
    stat_w[SB_PS]        = ps_r;
    stat_w[SB_TXB]       = tx_pend_r || tx_left_r != 4'h0;
    stat_w[SB_RXN]       = rx_new_r;
    stat_w[SB_RXE]       = rx_err_r;
    stat_w[SB_RSE]       = resp_err_r;
  end

  // Read data stand for one cycle only; unmapped offsets read zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !reg_rd) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      case (reg_addr)
        REG_CTRL: rdata_r <= {29'h0000_0000, ctrl_r};
        REG_STAT: rdata_r <= stat_w;
        REG_RXD:  rdata_r <= {24'h00_0000, rx_sh_r};
        REG_TXD:  rdata_r <= {23'h00_0000, tx_pend_r, tx_byte_r};
        default:  rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign reg_rdata = rdata_r;

  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_slv_wake;
    st_r == ST_SUSP && tx_pend_r && !fall_p;
  endsequence
  sequence s_master_answer;
    st_r == ST_SRES && fall_p;
  endsequence
  sequence s_resume_done;
    st_r == ST_MRES && rx_bit.valid && evt_cnt_r == RESUME_EVT - 4'h1 && !susp_hit && !deact_hit;
  endsequence

  AST_CUR_WHEN_LOW: assert property (cur_r != $past(cur_r) |-> !$past(line_lvl)
                                     || $past(st_r) == ST_SUSP || $past(st_r) == ST_SRES || $past(susp_hit))
    else $error("current changed while the voltage was high");
  AST_DEACT_QUIET: assert property (st_r == ST_DEACT |-> !cur_r)
    else $error("current drawn while deactivated");
  AST_SUSP_QUIET: assert property (st_r == ST_SUSP |-> !cur_r)
    else $error("current drawn while suspended");
  AST_DEACT_ENTRY: assert property (!line_lvl && run_cnt_r >= DEACT_CYC |=> st_r == ST_DEACT)
    else $error("long low did not deactivate");
  AST_SUSP_ENTRY: assert property (st_r == ST_ACT && susp_hit |=> st_r == ST_SUSP && !cur_r)
    else $error("long high did not suspend");
  AST_ACT_STAYS: assert property (st_r == ST_ACT && !susp_hit && !deact_hit |=> st_r == ST_ACT)
    else $error("activated state left without suspend");
  AST_RESUME_DONE: assert property (s_resume_done |=> st_r == ST_ACT)
    else $error("master resume did not activate after the idle bits");
  AST_SLV_WAKE: assert property (s_slv_wake |=> st_r == ST_SRES && cur_r)
    else $error("slave resume did not draw current");
  AST_RESP_LIMIT: assert property (st_r == ST_SRES && resp_cnt_r == RESP_CYC - 6'h01 && !fall_p
                                   |=> st_r == ST_SUSP && !cur_r && resp_err_r)
    else $error("resume wait overran the answer limit");
  AST_SOF_PROMPT: assert property (s_master_answer |=> st_r == ST_ACT
                                   && cur_r == $past(tx_byte_r[7]) && tx_left_r == TX_LAST)
    else $error("frame did not start at the first bit after slave resume");
  AST_IDLE_ZERO: assert property (st_r == ST_ACT && fall_p && !tx_pend_r && tx_left_r == 4'h0
                                  && !susp_hit && !deact_hit |=> !cur_r)
    else $error("idle bit sent as one");
  AST_PM_LOCK: assert property ($past(pm_r) != PM_INIT |-> pm_r == $past(pm_r))
    else $error("power mode changed without a supply cycle");
  AST_PM_LOW: assert property (pm_r == PM_INIT && nonact_p && !pm_full_p && !oif_full_p
                               |=> pm_r == PM_LOW)
    else $error("first non-activation frame did not select low power");
  AST_PS_SET: assert property (ps_cond && !oif_res_p && ps_cnt_r == PSW'(PS_CYC - 1) |=> ps_r)
    else $error("power saving not entered after the idle time");
  AST_PS_EXIT: assert property (ps_r && !ps_cond |=> !ps_r)
    else $error("power saving kept after a resume");
endmodule : swl_phy

// ### hdl/swl_pkg.sv
// Constants and types for the single-wire link slave physical layer
package swl_pkg;
  // Clock and link times in their own units
  localparam int CLK_NS     = 100;
  localparam int BIT_MIN_NS = 1000;
  localparam int BIT_MAX_NS = 5000;
  localparam int EXT_MIN_NS = 590;
  localparam int EXT_MAX_NS = 10000;
  localparam int DEACT_NS   = 100000;
  localparam int RESP_NS    = 5000;
  localparam int PS_MS      = 10;
  // Cycle counts: least times round up, longest times round down
  localparam logic [7:0]  PER_MIN_DEF = 8'((BIT_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  PER_MAX_DEF = 8'(BIT_MAX_NS / CLK_NS);
  localparam logic [7:0]  PER_MIN_EXT = 8'((EXT_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  PER_MAX_EXT = 8'(EXT_MAX_NS / CLK_NS);
  localparam logic [10:0] DEACT_CYC   = 11'(DEACT_NS / CLK_NS + 1);
  localparam logic [5:0]  RESP_CYC    = 6'(RESP_NS / CLK_NS);
  localparam int          PS_CYC_DEF  = PS_MS * 1000000 / CLK_NS;
  // Master resume: transition bit plus idle bits
  localparam logic [3:0]  RESUME_IDLE = 4'h8;
  localparam logic [3:0]  RESUME_EVT  = RESUME_IDLE + 4'h1;
  localparam logic [3:0]  TX_LAST     = 4'h7;
  // Register offsets
  localparam logic [3:0]  REG_CTRL = 4'h0;
  localparam logic [3:0]  REG_STAT = 4'h4;
  localparam logic [3:0]  REG_RXD  = 4'h8;
  localparam logic [3:0]  REG_TXD  = 4'hC;
  // Control bit positions (3 and up are write-only pulses)
  localparam int CB_EXT    = 0;
  localparam int CB_IDLE   = 1;
  localparam int CB_NMA    = 2;
  localparam int CB_PMLOW  = 3;
  localparam int CB_PMFULL = 4;
  localparam int CB_NONACT = 5;
  localparam int CB_OIFFUL = 6;
  localparam int CB_OIFRES = 7;
  // Status field positions
  localparam int SB_ST  = 0;
  localparam int SB_PM  = 3;
  localparam int SB_PS  = 5;
  localparam int SB_TXB = 6;
  localparam int SB_RXN = 7;
  localparam int SB_RXE = 8;
  localparam int SB_RSE = 9;
  localparam int TB_PND = 8;
  localparam logic [2:0] CTRL_RST = 3'h0;

  typedef enum logic [2:0] {ST_DEACT, ST_SUSP, ST_MRES, ST_SRES, ST_ACT} swl_state_t;
  typedef enum logic [1:0] {PM_INIT, PM_LOW, PM_FULL} swl_pm_t;
  typedef struct packed {
    logic valid;
    logic val;
    logic err;
  } swl_bit_t;
  typedef struct packed {
    logic nma;
    logic idle;
    logic ext;
  } swl_ctrl_t;
endpackage : swl_pkg

// ### hdl/swl_bit_dec.sv
// Bit decoder: synchronises the master voltage and classifies each bit
`timescale 1ns/1ps
module swl_bit_dec
  import swl_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic volt_pin,
  input  wire logic ext_en,
  output logic      line_lvl,
  output logic      rise_p,
  output logic      fall_p,
  output swl_bit_t  rx_bit
);
  logic        sync1_r;
  logic        sync2_r;
  logic        have_r;
  logic [7:0]  per_cnt_r;
  logic [7:0]  hi_cnt_r;
  logic        rise_c;
  logic        is_one;
  logic        band_ok;
  logic        range_ok;
  logic [11:0] hi10;
  logic [11:0] per2;
  logic [11:0] per3;
  logic [11:0] per7;
  logic [11:0] per8;

  // Two-flop synchroniser; the first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= volt_pin;
      sync2_r <= sync1_r;
    end
  end

  // Level and edge pulses, all aligned to one cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      line_lvl <= 1'b0;
      rise_p   <= 1'b0;
      fall_p   <= 1'b0;
    end else begin
      line_lvl <= sync2_r;
      rise_p   <= sync2_r & ~line_lvl;
      fall_p   <= ~sync2_r & line_lvl;
    end
  end

  assign rise_c = sync2_r & ~line_lvl;

  // Period and high time restart at every rising edge
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      have_r    <= 1'b0;
      per_cnt_r <= 8'h00;
      hi_cnt_r  <= 8'h00;
    end else if (rise_c) begin
      have_r    <= 1'b1;
      per_cnt_r <= 8'h01;
      hi_cnt_r  <= 8'h01;
    end else begin
      if (per_cnt_r != 8'hFF)
        per_cnt_r <= per_cnt_r + 8'h01;
      if (sync2_r && hi_cnt_r != 8'hFF)
        hi_cnt_r <= hi_cnt_r + 8'h01;
    end
  end

  // Half-period decision, then tolerance bands as a check
  assign hi10     = 12'(hi_cnt_r) * 12'h00A;
  assign per2     = 12'(per_cnt_r) * 12'h002;
  assign per3     = 12'(per_cnt_r) * 12'h003;
  assign per7     = 12'(per_cnt_r) * 12'h007;
  assign per8     = 12'(per_cnt_r) * 12'h008;
  assign is_one   = {hi_cnt_r, 1'b0} > {1'b0, per_cnt_r};
  assign band_ok  = is_one ? (hi10 >= per7 && hi10 <= per8)
                           : (hi10 >= per2 && hi10 <= per3);
  assign range_ok = ext_en ? (per_cnt_r >= PER_MIN_EXT && per_cnt_r <= PER_MAX_EXT)
                           : (per_cnt_r >= PER_MIN_DEF && per_cnt_r <= PER_MAX_DEF);

  // One decoded bit per rising edge after the first
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rx_bit <= '0;
    end else begin
      rx_bit.valid <= rise_c && have_r;
      rx_bit.val   <= is_one;
      rx_bit.err   <= !(band_ok && range_ok);
    end
  end

  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  AST_BIT_CLASS: assert property (rise_c && have_r |=> rx_bit.valid && rx_bit.val == $past(is_one))
    else $error("bit value does not follow the half-period decision");
  AST_ONE_BAND: assert property (rise_c && have_r && range_ok && hi10 >= per7 && hi10 <= per8
                                 |=> rx_bit.val && !rx_bit.err)
    else $error("high phase in the one band was not accepted as one");
  AST_ZERO_BAND: assert property (rise_c && have_r && range_ok && hi10 >= per2 && hi10 <= per3
                                  |=> !rx_bit.val && !rx_bit.err)
    else $error("high phase in the zero band was not accepted as zero");
endmodule : swl_bit_dec

// ### dv/swl_master_model.sv
// Link master model: drives the voltage line and samples the slave current
`timescale 1ns/1ps
module swl_master_model (
  output logic      master_voltage_signal,
  input  wire logic slave_current_signal
);
  localparam int PER_NS  = 800;  // Link bit period, inside the extended range
  localparam int SKEW_NS = 17;   // Keeps edges set by hold, and bits sent straight after one, between clock edges, so their sampling has no race

  // Line low until the bench activates it
  initial master_voltage_signal = 1'b0;

  // Hold the line at one level for a span
  task automatic hold(input logic lvl, input int ns);
    #(SKEW_NS);
    master_voltage_signal = lvl;
    #(ns);
  endtask : hold

  // One bit: rising edge, high phase by value, then low until the next bit
  task automatic bit_tx(input logic val, output logic got);
    int hi;
    hi = val ? PER_NS * 3 / 4 : PER_NS / 4;
    master_voltage_signal = 1'b1;
    #(hi / 2);
    got = slave_current_signal;  // Sampled mid high phase only
    #(hi - hi / 2);
    master_voltage_signal = 1'b0;
    #(PER_NS - hi);
  endtask : bit_tx

  // Resume from suspend: transition low phase, then idle zero bits
  task automatic master_resume();
    logic g;
    hold(1'b0, PER_NS * 3 / 4);
    repeat (10) bit_tx(1'b0, g);
  endtask : master_resume
endmodule : swl_master_model

// ### dv/tb_swl_phy.sv
// Self-checking bench for the single-wire link slave physical layer
`timescale 1ns/1ps
module tb_swl_phy;
  import swl_pkg::*;
  localparam int PS = 200;  // Short power saving delay keeps the run brief
  logic        sys_clk, sys_rst, mvs, cur, reg_wr, reg_rd, rd_d;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, lfsr_r;
  logic [31:0] exp_q[$], msk_q[$];
  logic [7:0]  d, g;
  int          fail_count, n_tests;

  swl_phy #(.PS_CYC(PS)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .master_voltage_signal(mvs),
    .slave_current_signal(cur), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  swl_master_model mst (.master_voltage_signal(mvs), .slave_current_signal(cur));

  // 10 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
    n_tests++;
    if ((got & msk) !== (exp & msk)) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got & msk, exp & msk);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read with the expected answer noted for the monitor
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask : rd

  // Current checked between edges so the flop update has landed
  task automatic chk_cur(input logic e);
    @(negedge sys_clk);
    chk({31'h0, cur}, {31'h0, e}, 32'h0000_0001);
  endtask : chk_cur

  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
  endtask : do_reset

  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  // Read answers stand only in the cycle after the strobe
  always @(posedge sys_clk) begin
    if (rd_d === 1'b1) begin
      chk(reg_rdata, exp_q.pop_front(), msk_q.pop_front());
    end
    rd_d <= reg_rd;
  end

  // Watchdog well beyond the expected run of about 0.2 ms
  initial begin
    #2000000;
    fail_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    summarize();
  end

  initial begin
    {sys_rst, reg_wr, reg_rd, rd_d} = 4'h8;
    reg_addr   = 4'h0;
    reg_wdata  = 32'h0000_0000;
    lfsr_r     = 32'haa19;
    fail_count = 0;
    n_tests    = 0;
    do_reset();
    rd(REG_STAT, 32'h0000_0000, 32'h0000_003F);
    rd(4'h2, 32'h0000_0000, 32'hFFFF_FFFF);
    chk_cur(1'b0);
    $display("Test reset done");
    mst.hold(1'b1, 2000);
    rd(REG_STAT, 32'h0000_0001, 32'h0000_0007);
    wr(REG_CTRL, 32'h0000_0001);
    mst.master_resume();
    rd(REG_STAT, 32'h0000_0004, 32'h0000_0007);
    lfsr_r = lfsr(lfsr_r);
    d = lfsr_r[7:0];
    for (int i = 7; i >= 0; i--) mst.bit_tx(d[i], g[0]);
    mst.hold(1'b1, 12000);
    rd(REG_RXD, {24'h0, d}, 32'h0000_00FF);
    rd(REG_STAT, 32'h0000_0001, 32'h0000_0007);
    chk_cur(1'b0);
    $display("Test master resume and receive done");
    lfsr_r = lfsr(lfsr_r);
    wr(REG_TXD, {24'h0, lfsr_r[7:0]});
    rd(REG_STAT, 32'h0000_0003, 32'h0000_0007);
    chk_cur(1'b1);
    // First answer comes late: the wait times out, then the slave draws current again
    repeat (55) @(posedge sys_clk);
    rd(REG_STAT, 32'h0000_0203, 32'h0000_0207);
    chk_cur(1'b1);
    mst.hold(1'b0, 600);
    for (int i = 7; i >= 0; i--) mst.bit_tx(1'b0, g[i]);
    chk({24'h0, g}, {24'h0, lfsr_r[7:0]}, 32'h0000_00FF);
    mst.hold(1'b1, 12000);
    rd(REG_STAT, 32'h0000_0001, 32'h0000_0007);
    chk_cur(1'b0);
    $display("Test slave resume and transmit done");
    // Master takes the line down for longer than the deactivation time
    mst.hold(1'b0, 110000);
    rd(REG_STAT, 32'h0000_0000, 32'h0000_0007);
    chk_cur(1'b0);
    wr(REG_CTRL, 32'h0000_0003);
    rd(REG_STAT, 32'h0000_0000, 32'h0000_0020);
    repeat (PS + 20) @(posedge sys_clk);
    rd(REG_STAT, 32'h0000_0020, 32'h0000_0020);
    wr(REG_CTRL, 32'h0000_0083);
    rd(REG_STAT, 32'h0000_0000, 32'h0000_0020);
    repeat (PS + 20) @(posedge sys_clk);
    rd(REG_STAT, 32'h0000_0020, 32'h0000_0020);
    wr(REG_CTRL, 32'h0000_0001);
    rd(REG_STAT, 32'h0000_0000, 32'h0000_0020);
    $display("Test deactivation and power saving done");
    for (int i = 0; i < 4; i++) begin
      do_reset();
      wr(REG_CTRL, 32'h0000_0008 << i);
      wr(REG_CTRL, 32'h0000_0008 << (i ^ 1));
      rd(REG_STAT, (i % 2 == 1) ? 32'h0000_0010 : 32'h0000_0008, 32'h0000_0018);
    end
    $display("Test power modes done");
    summarize();
  end
endmodule : tb_swl_phy
